// *** ltgm_top.v ***
// Traffic generator, checker and data FIFO for a packet link sanity test
// Assumes the link core shares ref_clk and speaks the segmented local bus
`timescale 1ns/1ps
`include "ltgm_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with valid and ready on both sides
module ltgm_fifo #(
  parameter W  = 8,                          // Word width
  parameter D  = `LTGM_FIFO_DEPTH,           // Depth in words
  parameter AW = 3                           // Pointer width, 2**AW == D
) (
  input  wire          ref_clk,              // Clock
  input  wire          rst,                  // Async reset, high
  input  wire          clk_en,               // Freezes state when low
  input  wire          in_valid,             // Write request
  output wire          in_ready,             // Space available
  input  wire [W-1:0]  in_data,              // Write data
  output wire          out_valid,            // Data available
  input  wire          out_ready,            // Read request
  output wire [W-1:0]  out_data              // Head word
);
  reg  [W-1:0] mem_reg [0:D-1];              // Storage array
  reg  [AW:0]  wr_ptr_reg;                   // Write pointer with wrap bit
  reg  [AW:0]  rd_ptr_reg;                   // Read pointer with wrap bit
  wire         full;                         // All words used
  wire         empty;                        // No word held
  wire         push;                         // Write this cycle
  wire         pop;                          // Read this cycle

  assign full      = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                     (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty     = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign push      = in_valid & ~full & clk_en;
  assign pop       = out_ready & ~empty & clk_en;
  assign out_data  = mem_reg[rd_ptr_reg[AW-1:0]];

  // Pointer update
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

  // Storage write, no reset needed
  always @(posedge ref_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
endmodule // ltgm_fifo

////////////////////////////////////////////////////////////////////////////////
// Top: generator, checker, synchronisers and indicator chain
module ltgm_top #(
  parameter [15:0] PKT_COUNT = `LTGM_PKT_DEF, // Packets per run
  parameter        NSEG      = `LTGM_NSEG,    // Bus segments
  parameter        DW        = `LTGM_SEG_DW,  // Data bits per segment
  parameter        CW        = `LTGM_CHAN_W,  // Channel bits per segment
  parameter        SWAP_EN   = 0              // Reverse data bit order
) (
  input  wire               ref_clk,          // 50 MHz clock
  input  wire               rst,              // Async reset, high
  input  wire               clk_en,           // Freezes state when low
  input  wire               restart_in,       // User restart request
  input  wire               remote_aligned_in,// Remote receiver aligned
  input  wire               burst_mode_in,    // 1 burst, 0 packet mode
  input  wire               tx_only_in,       // Transmit-only operation
  input  wire               err_inject_in,    // User error injection request
  input  wire               gt_locked_in,     // Core transceiver lock
  input  wire               rx_aligned_in,    // Core receive alignment
  input  wire               tx_rdy_in,        // Core transmit ready
  input  wire               tx_ovf_in,        // Core transmit overflow
  input  wire               tx_unf_in,        // Core transmit underflow
  input  wire [NSEG-1:0]    rx_ena_in,        // Receive segment enables
  input  wire [NSEG-1:0]    rx_sop_in,        // Receive start markers
  input  wire [NSEG-1:0]    rx_eop_in,        // Receive end markers
  input  wire [NSEG-1:0]    rx_err_in,        // Receive error flags
  input  wire [NSEG*CW-1:0] rx_chan_in,       // Receive channels
  input  wire [NSEG*DW-1:0] rx_data_in,       // Receive data
  output reg  [NSEG-1:0]    tx_ena_out,       // Transmit segment enables
  output reg  [NSEG-1:0]    tx_sop_out,       // Transmit start markers
  output reg  [NSEG-1:0]    tx_eop_out,       // Transmit end markers
  output reg  [NSEG*CW-1:0] tx_chan_out,      // Transmit channels
  output reg  [NSEG*DW-1:0] tx_data_out,      // Transmit data
  output reg                inband_flow_control,    // In-band FC enable
  output reg                outofband_flow_control, // Out-of-band FC enable
  output reg                err_inject_out,   // Error injection pulse
  output wire               done_ind,         // All packets sent
  output wire               fail_ind,         // Core buffer error seen
  output wire               busy_ind,         // Generator active
  output wire               transceiver_lock_ind, // Transceiver locked
  output wire               aligned_ind,      // Receive aligned
  output wire               rx_busy_ind,      // Checker active
  output wire               rx_err_ind,       // Checker mismatch seen
  output wire               rx_done_ind       // All packets checked
);
  // Clock plan: at 12.5 Gb/s one 300 MHz clock serves core and bus
  // Above it the bus stays at 300 MHz and the core runs at 412 MHz
  localparam LBUS_MHZ = `LTGM_LBUS_CLK_MHZ;
  localparam CORE_MHZ_LOW  = `LTGM_CORE_LOW_MHZ;
  localparam CORE_MHZ_HIGH = `LTGM_CORE_HIGH_MHZ;

  // Effective count forced even and into range
  localparam [15:0] PKT_EVEN = {PKT_COUNT[15:1], 1'b0};
  localparam [15:0] TOTAL = (PKT_EVEN < `LTGM_PKT_MIN) ? `LTGM_PKT_MIN :
                            (PKT_EVEN > `LTGM_PKT_MAX) ? `LTGM_PKT_MAX : PKT_EVEN;
  localparam [15:0] NSEG16 = NSEG;
  localparam SW = DW + CW + 3;                // Segment slot width
  localparam WW = NSEG * SW;                  // FIFO word width
  localparam NU = `LTGM_UI_NUM;
  localparam NI = `LTGM_IND_NUM;

  // Generator and checker states
  localparam [1:0] G_IDLE = 2'h0;
  localparam [1:0] G_WAIT = 2'h1;
  localparam [1:0] G_SEND = 2'h2;
  localparam [1:0] G_DRAIN = 2'h3;
  localparam [1:0] C_IDLE = 2'h0;
  localparam [1:0] C_WAIT = 2'h1;
  localparam [1:0] C_RECV = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // User input synchronisers: three flops, accept when last two agree
  wire [NU-1:0] ui_raw;                       // Raw user inputs
  reg  [NU-1:0] ui_s1_reg;                    // First stage
  reg  [NU-1:0] ui_s2_reg;                    // Second stage
  reg  [NU-1:0] ui_s3_reg;                    // Third stage
  reg  [NU-1:0] ui_reg;                       // Accepted levels
  reg  [NU-1:0] ui_prev_reg;                  // Previous accepted levels
  assign ui_raw = {err_inject_in, tx_only_in, burst_mode_in,
                   remote_aligned_in, restart_in};

  genvar g;
  generate
    for (g = 0; g < NU; g = g + 1) begin : g_ui
      // Per-input chain
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          ui_s1_reg[g]   <= 1'b0;
          ui_s2_reg[g]   <= 1'b0;
          ui_s3_reg[g]   <= 1'b0;
          ui_reg[g]      <= 1'b0;
          ui_prev_reg[g] <= 1'b0;
        end else if (clk_en) begin
          ui_s1_reg[g]   <= ui_raw[g];
          ui_s2_reg[g]   <= ui_s1_reg[g];
          ui_s3_reg[g]   <= ui_s2_reg[g];
          ui_prev_reg[g] <= ui_reg[g];
          if (ui_s2_reg[g] == ui_s3_reg[g]) begin
            ui_reg[g] <= ui_s3_reg[g];        // Stable value taken
          end
        end
      end
    end
  endgenerate

  wire restart_rise = ui_reg[`LTGM_UI_RESTART] & ~ui_prev_reg[`LTGM_UI_RESTART];
  wire inj_rise     = ui_reg[`LTGM_UI_ERR_INJ] & ~ui_prev_reg[`LTGM_UI_ERR_INJ];
  wire burst_mode   = ui_reg[`LTGM_UI_BURST];
  wire tx_only      = ui_reg[`LTGM_UI_TX_ONLY];

  //////////////////////////////////////////////////////////////////////////////
  // Generator and checker state
  reg  [1:0]  gen_state_reg;                  // Generator state
  reg  [15:0] gen_cnt_reg;                    // Packets queued so far
  reg         gen_arm_reg;                    // Start pending
  reg         done_reg;                       // Run complete
  reg         fail_reg;                       // Sticky buffer error
  reg  [1:0]  chk_state_reg;                  // Checker state
  reg  [15:0] chk_cnt_reg;                    // Packets checked so far
  reg         chk_arm_reg;                    // Start pending
  reg         chk_err_reg;                    // Sticky mismatch
  reg         chk_done_reg;                   // All packets checked
  wire        gen_busy = (gen_state_reg != G_IDLE);
  wire        chk_busy = (chk_state_reg != C_IDLE);
  wire        restart_ok = restart_rise & ~gen_busy & ~chk_busy;
  wire        link_ok;                        // Link ready to carry traffic
  wire [15:0] remain = TOTAL - gen_cnt_reg;   // Packets still to queue
  wire [15:0] n_this = (remain >= NSEG16) ? NSEG16 : remain;
  wire [WW-1:0] gen_word;                     // Beat built for the FIFO
  wire        fifo_in_ready;                  // FIFO space
  wire        fifo_out_valid;                 // FIFO holds a beat
  wire [WW-1:0] fifo_out_data;                // FIFO head beat
  wire        push = (gen_state_reg == G_SEND) & fifo_in_ready;

  // Transmit-only uses the remote alignment input instead of local
  assign link_ok = gt_locked_in &
                   (tx_only ? ui_reg[`LTGM_UI_REMOTE_AL] : rx_aligned_in);

  // Beat builder: one packet per segment so each segment carries both markers
  generate
    for (g = 0; g < NSEG; g = g + 1) begin : g_gen
      localparam [15:0] GI = g;               // Segment index at counter width
      wire [15:0]   idx = gen_cnt_reg + GI;
      wire [CW-1:0] chan_pkt = {{(CW-8){1'b0}}, idx[7:0]};
      wire [CW-1:0] chan_bst = idx[0] ? `LTGM_BURST_CHAN_B
                                      : `LTGM_BURST_CHAN_A;
      assign gen_word[g*SW +: SW] = {
        (GI < n_this),                        // Enable
        1'b1, 1'b1,                           // Start and end markers
        burst_mode ? chan_bst : chan_pkt,
        {(DW/`LTGM_PKT_W){idx}}};             // Payload from packet index
    end
  endgenerate

  // Generator state machine
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gen_state_reg <= G_IDLE;
      gen_cnt_reg   <= 16'h0000;
      gen_arm_reg   <= 1'b1;
      done_reg      <= 1'b0;
      fail_reg      <= 1'b0;
    end else if (clk_en) begin
      if (restart_ok) begin
        gen_arm_reg <= 1'b1;
      end
      case (gen_state_reg)
        G_IDLE: begin
          if (gen_arm_reg) begin
            gen_arm_reg   <= 1'b0;
            gen_cnt_reg   <= 16'h0000;
            done_reg      <= 1'b0;
            fail_reg      <= 1'b0;
            gen_state_reg <= G_WAIT;
          end
        end
        G_WAIT: begin
          if (link_ok) begin
            gen_state_reg <= G_SEND;
          end
        end
        G_SEND: begin
          if (push) begin
            gen_cnt_reg <= gen_cnt_reg + n_this;
            if (n_this == remain) begin
              gen_state_reg <= G_DRAIN;
            end
          end
        end
        default: begin
          // Wait until every queued beat has gone to the core
          if (~fifo_out_valid) begin
            done_reg      <= 1'b1;
            gen_state_reg <= G_IDLE;
          end
        end
      endcase
      // Buffer error sets after any clear, so it wins
      if (tx_ovf_in | tx_unf_in) begin
        fail_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Beat FIFO between generator and core
  ltgm_fifo #(
    .W  (WW),
    .D  (`LTGM_FIFO_DEPTH),
    .AW (3)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .in_valid  (gen_state_reg == G_SEND),
    .in_ready  (fifo_in_ready),
    .in_data   (gen_word),
    .out_valid (fifo_out_valid),
    .out_ready (tx_rdy_in),
    .out_data  (fifo_out_data)
  );

  // Transmit output registers, enables low unless a beat moves
  integer b;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_ena_out  <= {NSEG{1'b0}};
      tx_sop_out  <= {NSEG{1'b0}};
      tx_eop_out  <= {NSEG{1'b0}};
      tx_chan_out <= {(NSEG*CW){1'b0}};
      tx_data_out <= {(NSEG*DW){1'b0}};
    end else if (clk_en) begin
      for (b = 0; b < NSEG; b = b + 1) begin
        // Enable only when a beat leaves while the core is ready
        tx_ena_out[b] <= fifo_out_valid & tx_rdy_in & fifo_out_data[b*SW+SW-1];
        if (fifo_out_valid & tx_rdy_in) begin
          tx_sop_out[b]          <= fifo_out_data[b*SW+SW-2];
          tx_eop_out[b]          <= fifo_out_data[b*SW+SW-3];
          tx_chan_out[b*CW +: CW] <= fifo_out_data[b*SW+DW +: CW];
          tx_data_out[b*DW +: DW] <= SWAP_EN ? bitrev(fifo_out_data[b*SW +: DW])
                                             : fifo_out_data[b*SW +: DW];
        end
      end
    end
  end

  // Bit order reversal of one segment
  function [DW-1:0] bitrev;
    input [DW-1:0] v;
    integer k;
    begin
      for (k = 0; k < DW; k = k + 1) begin
        bitrev[k] = v[DW-1-k];
      end
    end
  endfunction

  // Flow control enables follow sending, injection is a one-cycle pulse
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      inband_flow_control    <= 1'b0;
      outofband_flow_control <= 1'b0;
      err_inject_out         <= 1'b0;
    end else if (clk_en) begin
      inband_flow_control    <= (gen_state_reg == G_SEND);
      outofband_flow_control <= (gen_state_reg == G_SEND);
      err_inject_out         <= inj_rise & gen_busy;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checker: per-segment compare against the expected packet
  wire [NSEG-1:0] seg_ok;                     // Segment passes or idle
  reg  [15:0]     rx_n;                       // Enabled segments this beat
  generate
    for (g = 0; g < NSEG; g = g + 1) begin : g_chk
      localparam [15:0] GI = g;               // Segment index at counter width
      wire [15:0]   eidx = chk_cnt_reg + GI;
      wire [CW-1:0] echan = burst_mode ?
                            (eidx[0] ? `LTGM_BURST_CHAN_B : `LTGM_BURST_CHAN_A) :
                            {{(CW-8){1'b0}}, eidx[7:0]};
      assign seg_ok[g] = ~rx_ena_in[g] |
                         (rx_sop_in[g] & rx_eop_in[g] & ~rx_err_in[g] &
                          (rx_chan_in[g*CW +: CW] == echan) &
                          (rx_data_in[g*DW +: DW] == {(DW/`LTGM_PKT_W){eidx}}));
    end
  endgenerate

  // Count of enabled segments
  integer j;
  always @* begin
    rx_n = 16'h0000;
    for (j = 0; j < NSEG; j = j + 1) begin
      rx_n = rx_n + {15'h0000, rx_ena_in[j]};
    end
  end

  // Checker state machine
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chk_state_reg <= C_IDLE;
      chk_cnt_reg   <= 16'h0000;
      chk_arm_reg   <= 1'b1;
      chk_err_reg   <= 1'b0;
      chk_done_reg  <= 1'b0;
    end else if (clk_en) begin
      if (restart_ok) begin
        chk_arm_reg <= 1'b1;
      end
      case (chk_state_reg)
        C_IDLE: begin
          // Transmit-only leaves nothing to receive
          if (chk_arm_reg) begin
            chk_arm_reg   <= 1'b0;
            chk_cnt_reg   <= 16'h0000;
            chk_err_reg   <= 1'b0;
            chk_done_reg  <= 1'b0;
            chk_state_reg <= tx_only ? C_IDLE : C_WAIT;
          end
        end
        C_WAIT: begin
          if (gt_locked_in & rx_aligned_in) begin
            chk_state_reg <= C_RECV;
          end
        end
        C_RECV: begin
          if (|rx_ena_in) begin
            if (~&seg_ok) begin
              chk_err_reg <= 1'b1;
            end
            chk_cnt_reg <= chk_cnt_reg + rx_n;
            if (chk_cnt_reg + rx_n >= TOTAL) begin
              chk_done_reg  <= 1'b1;
              chk_state_reg <= C_IDLE;
            end
          end
        end
        default: begin
          chk_state_reg <= C_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Indicator chain: three registers before each output
  wire [NI-1:0] ind_vec;                      // Indicator sources
  reg  [NI-1:0] ind_p1_reg;                   // Stage one
  reg  [NI-1:0] ind_p2_reg;                   // Stage two
  reg  [NI-1:0] ind_p3_reg;                   // Stage three, drives pins
  assign ind_vec = {chk_done_reg, chk_err_reg, chk_busy, rx_aligned_in,
                    gt_locked_in, gen_busy, fail_reg, done_reg};

  // Shift the chain
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ind_p1_reg <= {NI{1'b0}};
      ind_p2_reg <= {NI{1'b0}};
      ind_p3_reg <= {NI{1'b0}};
    end else if (clk_en) begin
      ind_p1_reg <= ind_vec;
      ind_p2_reg <= ind_p1_reg;
      ind_p3_reg <= ind_p2_reg;
    end
  end

  assign done_ind             = ind_p3_reg[`LTGM_IND_DONE];
  assign fail_ind             = ind_p3_reg[`LTGM_IND_FAIL];
  assign busy_ind             = ind_p3_reg[`LTGM_IND_BUSY];
  assign transceiver_lock_ind = ind_p3_reg[`LTGM_IND_LOCK];
  assign aligned_ind          = ind_p3_reg[`LTGM_IND_ALIGN];
  assign rx_busy_ind          = ind_p3_reg[`LTGM_IND_RX_BUSY];
  assign rx_err_ind           = ind_p3_reg[`LTGM_IND_RX_ERR];
  assign rx_done_ind          = ind_p3_reg[`LTGM_IND_RX_DONE];
endmodule // ltgm_top

// *** ltgm_defines.vh ***
// Constants shared by the link traffic generator and monitor
// Assumes inclusion by bare name from design files in the same folder
`ifndef LTGM_DEFINES_VH
`define LTGM_DEFINES_VH

// Packet count limits and the default count
`define LTGM_PKT_MIN       16'h0002
`define LTGM_PKT_MAX       16'hFFFE
`define LTGM_PKT_DEF       16'h0064

// Burst mode channel pair
`define LTGM_BURST_CHAN_A  11'h005
`define LTGM_BURST_CHAN_B  11'h00A

// Segmented bus shape
`define LTGM_NSEG          4
`define LTGM_SEG_DW        128
`define LTGM_CHAN_W        11
`define LTGM_PKT_W         16
`define LTGM_FIFO_DEPTH    8

// Clock plan figures in MHz and lane rates in Mb/s
`define LTGM_REF_CLK_MHZ   50
`define LTGM_LOW_RATE_MBPS 12500
`define LTGM_LBUS_CLK_MHZ  300
`define LTGM_CORE_LOW_MHZ  300
`define LTGM_CORE_HIGH_MHZ 412

// User input positions in the synchroniser vector
`define LTGM_UI_RESTART    0
`define LTGM_UI_REMOTE_AL  1
`define LTGM_UI_BURST      2
`define LTGM_UI_TX_ONLY    3
`define LTGM_UI_ERR_INJ    4
`define LTGM_UI_NUM        5

// Indicator positions in the output chain
`define LTGM_IND_DONE      0
`define LTGM_IND_FAIL      1
`define LTGM_IND_BUSY      2
`define LTGM_IND_LOCK      3
`define LTGM_IND_ALIGN     4
`define LTGM_IND_RX_BUSY   5
`define LTGM_IND_RX_ERR    6
`define LTGM_IND_RX_DONE   7
`define LTGM_IND_NUM       8

`endif

// *** ltgm_top_sva.sv ***
// Port checker for ltgm_top
// Assumes default shape: 4 segments, 11-bit channels
`timescale 1ns/1ps
`include "ltgm_defines.vh"
module ltgm_top_sva (
  input wire logic        ref_clk,              // Clock
  input wire logic        rst,                  // Reset
  input wire logic        tx_rdy_in,            // Ready
  input wire logic        tx_ovf_in,            // Overflow
  input wire logic        tx_unf_in,            // Underflow
  input wire logic        burst_mode_in,        // Mode pin
  input wire logic        gt_locked_in,         // Lock pin
  input wire logic        rx_aligned_in,        // Align pin
  input wire logic [3:0]  tx_ena_out,           // Enables
  input wire logic [3:0]  tx_sop_out,           // Starts
  input wire logic [3:0]  tx_eop_out,           // Ends
  input wire logic [43:0] tx_chan_out,          // Channels
  input wire logic        err_inject_out,       // Inject pulse
  input wire logic        fail_ind,             // Fail
  input wire logic        transceiver_lock_ind, // Lock
  input wire logic        aligned_ind,          // Align
  input wire logic        busy_ind,             // Generator busy
  input wire logic        inband_flow_control,  // In-band enable
  input wire logic        outofband_flow_control // Out-of-band enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Pin change shows on the indicator three cycles on
  sequence s_lock_seen; ##3 $rose(transceiver_lock_ind); endsequence
  sequence s_align_seen; ##3 $rose(aligned_ind); endsequence
  // Both enables come up together, busy indicator follows
  sequence s_fc_on; outofband_flow_control ##1 busy_ind; endsequence
  AST_RDY: assert property (|tx_ena_out |-> $past(tx_rdy_in))
    else $error("beat without ready");
  AST_MARK: assert property (|tx_ena_out |-> (tx_sop_out & tx_eop_out) == tx_ena_out)
    else $error("markers missing");
  AST_SEGS: assert property ((tx_ena_out & (tx_ena_out + 4'h1)) == 4'h0)
    else $error("enables not low contiguous");
  AST_BURST: assert property (tx_ena_out[1] && burst_mode_in |->
    tx_chan_out[21:0] == {`LTGM_BURST_CHAN_B, `LTGM_BURST_CHAN_A}) else $error("burst channel");
  AST_PKT: assert property (tx_ena_out[1] && !burst_mode_in |->
    tx_chan_out[21:0] == {3'h0, tx_chan_out[7:0] + 8'h01, tx_chan_out[10:0]})
    else $error("packet channel");
  AST_LOCK: assert property ($rose(gt_locked_in) |-> s_lock_seen)
    else $error("lock indicator");
  AST_ALIGN: assert property ($rose(rx_aligned_in) |-> s_align_seen)
    else $error("align indicator");
  AST_FAIL: assert property (tx_ovf_in || tx_unf_in |-> ##4 fail_ind)
    else $error("fail indicator");
  AST_INJ: assert property ($rose(err_inject_out) |=> !err_inject_out)
    else $error("inject pulse too long");
  AST_FC: assert property ($rose(inband_flow_control) |-> s_fc_on)
    else $error("flow control enable");
endmodule // ltgm_top_sva
bind ltgm_top ltgm_top_sva i_ltgm_top_sva (.ref_clk, .rst, .tx_rdy_in, .tx_ovf_in,
  .tx_unf_in, .burst_mode_in, .gt_locked_in, .rx_aligned_in, .tx_ena_out, .tx_sop_out,
  .tx_eop_out, .tx_chan_out, .err_inject_out, .fail_ind, .transceiver_lock_ind, .aligned_ind,
  .busy_ind, .inband_flow_control, .outofband_flow_control);

// *** ltgm_core_model.sv ***
// Loopback model of the link core
// Assumes the block's clock and default bus shape
`timescale 1ns/1ps
module ltgm_core_model (
  input  wire         ref_clk, // Clock
  input  wire         rst,     // Reset
  input  wire         stall,   // Holds ready low
  input  wire [3:0]   tx_ena,  // Beat enables
  input  wire [43:0]  tx_chan, // Channels
  input  wire [511:0] tx_data, // Data
  output reg          locked,  // Lock
  output reg          aligned, // Alignment
  output wire         tx_rdy,  // Ready
  output reg          tx_ovf,  // Overflow
  output reg  [3:0]   rx_ena,  // Echo enables
  output reg  [43:0]  rx_chan, // Echo channels
  output reg  [511:0] rx_data  // Echo data
);
  reg [4:0] up_cnt; // Bring-up delay
  reg       rdy_q;  // Ready last cycle
  assign tx_rdy = !stall;
  // Bring-up, overflow watch, echo; idle lines show inverted data
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      up_cnt <= 5'h00;
      {locked, aligned, tx_ovf, rdy_q, rx_ena} <= 8'h00;
    end else begin
      up_cnt <= up_cnt + {4'h0, ~up_cnt[4]};
      locked <= up_cnt[4];
      aligned <= locked;
      rdy_q <= tx_rdy;
      tx_ovf <= |tx_ena & !rdy_q;
      rx_ena <= tx_ena;
      rx_chan <= |tx_ena ? tx_chan : ~rx_chan;
      rx_data <= |tx_ena ? tx_data : ~rx_data;
    end
  end
endmodule // ltgm_core_model

// *** ltgm_top_bench.sv ***
// Bench for ltgm_top with the core model looped back
// Assumes design, checker and model are compiled first
`timescale 1ns/1ps
`include "ltgm_defines.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module ltgm_top_bench;
  localparam N = 48; // Packets per run
  reg ref_clk = 0, rst = 1, restart_in = 0, remote_aligned_in = 0, burst_mode_in = 0;
  reg tx_only_in = 0, err_inject_in = 0, tx_unf_in = 0, stall = 0, stall_en = 0, rx_bad = 0;
  reg [4:0] tick = 5'h00;                       // Stall rhythm
  reg [2:0] rows [0:2] = '{3'h0, 3'h7, 3'h2};   // Burst, stall, poke
  reg [10:0] cap_chan [0:127], ec;              // Seen and expected channels
  reg [15:0] cap_dat [0:127];                   // Seen data
  integer cnt = 0, error_cnt = 0, compares = 0, r, k, s, w;
  wire lk, al, rdy, ovf, done, fail, busy, lki, ali, rxb, rxe, rxd;
  wire [3:0] ena, sop, eop, rxen;
  wire [43:0] chan, rxch;
  wire [511:0] dat, rxdt;
  always #10 ref_clk = ~ref_clk;
  // Stall pattern and packet capture
  always @(posedge ref_clk) begin
    tick <= tick + 5'h01;
    stall <= stall_en & tick[4];
    for (s = 0; s < 4; s++)
      if (ena[s] && cnt < 128) begin
        cap_chan[cnt] = chan[s*11+:11];
        cap_dat[cnt] = dat[s*128+:16];
        cnt = cnt + 1;
      end
  end
  ltgm_core_model i_ltgm_core_model (.ref_clk(ref_clk), .rst(rst), .stall(stall),
    .tx_ena(ena), .tx_chan(chan), .tx_data(dat), .locked(lk), .aligned(al), .tx_rdy(rdy),
    .tx_ovf(ovf), .rx_ena(rxen), .rx_chan(rxch), .rx_data(rxdt));
  ltgm_top #(.PKT_COUNT(N)) i_ltgm_top (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
    .restart_in(restart_in), .remote_aligned_in(remote_aligned_in),
    .burst_mode_in(burst_mode_in), .tx_only_in(tx_only_in), .err_inject_in(err_inject_in),
    .gt_locked_in(lk), .rx_aligned_in(al), .tx_rdy_in(rdy), .tx_ovf_in(ovf),
    .tx_unf_in(tx_unf_in), .rx_ena_in(rxen), .rx_sop_in(rxen), .rx_eop_in(rxen),
    .rx_err_in(rxen & {4{rx_bad}}), .rx_chan_in(rxch), .rx_data_in(rxdt), .tx_ena_out(ena),
    .tx_sop_out(sop), .tx_eop_out(eop), .tx_chan_out(chan), .tx_data_out(dat),
    .inband_flow_control(), .outofband_flow_control(), .err_inject_out(),
    .done_ind(done), .fail_ind(fail), .busy_ind(busy), .transceiver_lock_ind(lki),
    .aligned_ind(ali), .rx_busy_ind(rxb), .rx_err_ind(rxe), .rx_done_ind(rxd));
  // Pulse restart (0) or error injection (1) for six cycles
  task pulse(input reg inj);
    begin
      @(posedge ref_clk);
      if (inj) err_inject_in <= 1'b1;
      else restart_in <= 1'b1;
      repeat (6) @(posedge ref_clk);
      {restart_in, err_inject_in} <= 2'h0;
    end
  endtask
  // Wait for busy, then for both sides idle; a hang counts as a mismatch
  task wait_run(input reg poke);
    begin
      w = 0;
      while (busy !== 1'b1 && w < 60) begin @(posedge ref_clk); w++; end
      if (poke) pulse(1'b0);
      if (poke) pulse(1'b1);
      while ((busy | rxb) !== 1'b0 && w < 3000) begin @(posedge ref_clk); w++; end
      repeat (6) @(posedge ref_clk);
      `CHK({busy, rxb}, 2'h0)
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    `CHK({done, fail, busy, rxb}, 4'h0)
    rst <= 1'b0;
    wait_run(1'b0);
    `CHK({lki, ali, cnt}, {2'h3, 32'd48})
    $display("test reset run done");
    // Table runs: channel, data and indicator checks
    for (r = 0; r < 3; r++) begin
      {burst_mode_in, stall_en} <= rows[r][2:1];
      repeat (8) @(posedge ref_clk);
      cnt = 0;
      pulse(1'b0);
      wait_run(rows[r][0]);
      `CHK({done, rxd, rxe, fail, busy, cnt}, {5'h18, 32'd48})
      for (k = 0; k < N; k++) begin
        ec = rows[r][2] ? (k[0] ? `LTGM_BURST_CHAN_B : `LTGM_BURST_CHAN_A) : {3'h0, k[7:0]};
        `CHK({cap_chan[k], cap_dat[k]}, {ec, k[15:0]})
      end
      $display("test %0d done", r);
    end
    // Transmit-only holds until the remote side reports alignment
    {tx_only_in, stall_en} <= 2'h2;
    repeat (8) @(posedge ref_clk);
    cnt = 0;
    pulse(1'b0);
    repeat (40) @(posedge ref_clk);
    `CHK({busy, cnt}, {1'b1, 32'd0})
    remote_aligned_in <= 1'b1;
    wait_run(1'b0);
    `CHK({done, cnt}, {1'b1, 32'd48})
    tx_unf_in <= 1'b1;
    @(posedge ref_clk) tx_unf_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    `CHK(fail, 1'b1)
    $display("test fail flag done");
    // Flagged receive segments must reach the checker's error indicator
    {tx_only_in, rx_bad} <= 2'h1;
    pulse(1'b0);
    wait_run(1'b0);
    `CHK({rxe, rxd, fail}, 3'h6)
    $display("test receive error done");
    report_and_stop;
  end
  // Watchdog
  initial begin
    repeat (30000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop;
  end
endmodule // ltgm_top_bench
